// file: rtl/dpw_pkg.sv
package dpw_pkg;
  // ****************************************************************
  // Address byte layout.
  // ****************************************************************
  // Device-type prefix value is arbitrary.
  localparam logic [5:0] DEV_PREFIX_DEF = 6'h2c;
  localparam int ADDR_PREFIX_MSB = 7;
  localparam int ADDR_PREFIX_LSB = 2;
  localparam int ADDR_SEL_BIT = 1;
  localparam int ADDR_RW_BIT = 0;
  // ****************************************************************
  // Instruction byte layout and wiper codes.
  // ****************************************************************
  localparam int INSTR_RS_BIT = 6;
  localparam int INSTR_SD_BIT = 5;
  localparam logic [7:0] WIPER_MIDSCALE = 8'h80;
  localparam logic [255:0] TAP_ZERO = 256'h1;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] IDX_ADDR = 2'h0;
  localparam logic [1:0] IDX_INSTR = 2'h1;
  localparam logic [1:0] IDX_DATA = 2'h2;
  // ****************************************************************
  // Serial clock timing.
  // ****************************************************************
  localparam int SYS_CLK_PERIOD_PS = 4000;
  localparam int SCL_PERIOD_MIN_PS = 2500000;
  localparam int SCL_QTR_CYC =
    (SCL_PERIOD_MIN_PS + 4 * SYS_CLK_PERIOD_PS - 1) / (4 * SYS_CLK_PERIOD_PS);
endpackage

// file: rtl/dpw_i2c_if.sv
`timescale 1ns/1ps
interface dpw_i2c_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic s_sda_o;
  logic s_sda_oe_n;
  logic sda;
  // Open-drain wired AND; a released line floats high.
  assign sda = ~((~m_sda_oe_n & ~m_sda_o) | (~s_sda_oe_n & ~s_sda_o));
  modport master (output scl, output m_sda_o, output m_sda_oe_n, input sda);
  modport slave (input scl, input sda, output s_sda_o, output s_sda_oe_n);
endinterface

// file: rtl/dpw_slave.sv
`timescale 1ns/1ps
module dpw_slave #(
  parameter logic [5:0] DEV_PREFIX = dpw_pkg::DEV_PREFIX_DEF
) (
  input wire logic sys_clk,
  input wire logic rstn,
  dpw_i2c_if.slave bus,
  input wire logic address_select_pin,
  output logic [7:0] wiper_position_register,
  output logic [255:0] tap_select,
  output logic shutdown_active
);
  import dpw_pkg::*;

  typedef enum logic [2:0] {
    DS_IDLE = 3'b000,
    DS_RX = 3'b001,
    DS_RX_ACK = 3'b010,
    DS_TX = 3'b011,
    DS_TX_ACK = 3'b100,
    DS_WAIT_STOP = 3'b101
  } dpw_dstate_t;

  // ****************************************************************
  // Line sampling and condition detection.
  // ****************************************************************
  logic scl_q_r;
  logic scl_p_r;
  logic sda_q_r;
  logic sda_p_r;
  logic adsel_r;
  logic start_ev;
  logic stop_ev;
  logic scl_rise;
  logic scl_fall;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      scl_q_r <= 1'b1;
      scl_p_r <= 1'b1;
      sda_q_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else begin
      scl_q_r <= bus.scl;
      scl_p_r <= scl_q_r;
      sda_q_r <= bus.sda;
      sda_p_r <= sda_q_r;
    end
  end

  // The pin may be driven live, so it is followed rather than latched once.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      adsel_r <= 1'b0;
    end else begin
      adsel_r <= address_select_pin;
    end
  end

  assign start_ev = scl_q_r & scl_p_r & sda_p_r & ~sda_q_r;
  assign stop_ev = scl_q_r & scl_p_r & ~sda_p_r & sda_q_r;
  assign scl_rise = scl_q_r & ~scl_p_r;
  assign scl_fall = ~scl_q_r & scl_p_r;

  // ****************************************************************
  // Byte engine.
  // ****************************************************************
  dpw_dstate_t state_r;
  logic [3:0] bitcnt_r;
  logic [1:0] idx_r;
  logic [7:0] shift_r;
  logic rw_r;
  logic ack_seen_r;
  logic oe_n_r;
  logic byte_done;
  logic addr_hit;
  logic ack_ok;
  logic wr_instr;
  logic wr_data;

  assign byte_done = (state_r == DS_RX) && scl_fall && (bitcnt_r == BITS_PER_BYTE);
  assign addr_hit = (shift_r[ADDR_PREFIX_MSB:ADDR_PREFIX_LSB] == DEV_PREFIX)
    && (shift_r[ADDR_SEL_BIT] == adsel_r);
  // Bytes past the data byte are not acknowledged, which makes the master stop.
  assign ack_ok = (idx_r == IDX_ADDR) ? addr_hit : (!rw_r && (idx_r <= IDX_DATA));
  assign wr_instr = byte_done && !rw_r && (idx_r == IDX_INSTR);
  assign wr_data = byte_done && !rw_r && (idx_r == IDX_DATA);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= DS_IDLE;
      bitcnt_r <= 4'h0;
      idx_r <= 2'h0;
      shift_r <= 8'h00;
      rw_r <= 1'b0;
      ack_seen_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else if (stop_ev) begin
      state_r <= DS_IDLE;
      oe_n_r <= 1'b1;
    end else if (start_ev) begin
      state_r <= DS_RX;
      bitcnt_r <= 4'h0;
      idx_r <= IDX_ADDR;
      oe_n_r <= 1'b1;
    end else begin
      case (state_r)
        DS_IDLE: begin
          oe_n_r <= 1'b1;
        end
        DS_RX: begin
          if (scl_rise && (bitcnt_r < BITS_PER_BYTE)) begin
            shift_r <= {shift_r[6:0], sda_q_r};
            bitcnt_r <= bitcnt_r + 4'h1;
          end else if (byte_done) begin
            if (ack_ok) begin
              oe_n_r <= 1'b0;
              state_r <= DS_RX_ACK;
              if (idx_r == IDX_ADDR) begin
                rw_r <= shift_r[ADDR_RW_BIT];
              end
            end else begin
              state_r <= DS_WAIT_STOP;
            end
          end
        end
        DS_RX_ACK: begin
          if (scl_fall) begin
            bitcnt_r <= 4'h0;
            idx_r <= idx_r + 2'h1;
            if (rw_r) begin
              oe_n_r <= wiper_position_register[7];
              shift_r <= {wiper_position_register[6:0], 1'b0};
              state_r <= DS_TX;
            end else begin
              oe_n_r <= 1'b1;
              state_r <= DS_RX;
            end
          end
        end
        DS_TX: begin
          if (scl_rise) begin
            bitcnt_r <= bitcnt_r + 4'h1;
          end else if (scl_fall) begin
            if (bitcnt_r == BITS_PER_BYTE) begin
              oe_n_r <= 1'b1;
              state_r <= DS_TX_ACK;
            end else begin
              oe_n_r <= shift_r[7];
              shift_r <= {shift_r[6:0], 1'b0};
            end
          end
        end
        DS_TX_ACK: begin
          if (scl_rise) begin
            ack_seen_r <= ~sda_q_r;
          end else if (scl_fall) begin
            bitcnt_r <= 4'h0;
            if (ack_seen_r) begin
              oe_n_r <= wiper_position_register[7];
              shift_r <= {wiper_position_register[6:0], 1'b0};
              state_r <= DS_TX;
            end else begin
              state_r <= DS_WAIT_STOP;
            end
          end
        end
        DS_WAIT_STOP: begin
          oe_n_r <= 1'b1;
        end
        default: begin
          state_r <= DS_IDLE;
          oe_n_r <= 1'b1;
        end
      endcase
    end
  end

  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe_n = oe_n_r;

  // ****************************************************************
  // Wiper register and shutdown control.
  // ****************************************************************
  logic rs_pend_r;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wiper_position_register <= WIPER_MIDSCALE;
      shutdown_active <= 1'b0;
      rs_pend_r <= 1'b0;
    end else if (wr_instr) begin
      // The top instruction bit is never looked at.
      shutdown_active <= shift_r[INSTR_SD_BIT];
      rs_pend_r <= shift_r[INSTR_RS_BIT];
      if (shift_r[INSTR_RS_BIT]) begin
        wiper_position_register <= WIPER_MIDSCALE;
      end
    end else if (wr_data && !rs_pend_r) begin
      // Stored even in shutdown; the taps only follow once it ends.
      wiper_position_register <= shift_r;
    end
  end

  // ****************************************************************
  // Tap decode.
  // ****************************************************************
  // Shutdown shorts the wiper to B, the same switch as code zero.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tap_select <= TAP_ZERO << WIPER_MIDSCALE;
    end else if (shutdown_active) begin
      tap_select <= TAP_ZERO;
    end else begin
      tap_select <= TAP_ZERO << wiper_position_register;
    end
  end

endmodule

// file: rtl/dpw_master.sv
`timescale 1ns/1ps
module dpw_master #(
  parameter logic [5:0] DEV_PREFIX = dpw_pkg::DEV_PREFIX_DEF,
  parameter int QTR_CYC = dpw_pkg::SCL_QTR_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  dpw_i2c_if.master bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic cmd_addr_sel,
  input wire logic [7:0] cmd_instr,
  input wire logic [7:0] cmd_data,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack
);
  import dpw_pkg::*;

  if ((QTR_CYC < 1) || (QTR_CYC > 65535)) begin : g_chk
    $error("QTR_CYC out of range");
  end

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_START = 3'b001,
    HS_BIT = 3'b010,
    HS_ACK = 3'b011,
    HS_STOP = 3'b100
  } dpw_hstate_t;

  localparam logic [15:0] QTR_LAST = 16'(QTR_CYC - 1);

  // ****************************************************************
  // Quarter-bit divider.
  // ****************************************************************
  dpw_hstate_t state_r;
  logic [15:0] div_r;
  logic tick;

  assign tick = (state_r != HS_IDLE) && (div_r == QTR_LAST);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      div_r <= 16'h0000;
    end else if ((state_r == HS_IDLE) || tick) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  // ****************************************************************
  // Transaction sequencer.
  // ****************************************************************
  logic [1:0] ph_r;
  logic [2:0] bit_r;
  logic [1:0] idx_r;
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  logic [7:0] instr_r;
  logic [7:0] data_r;
  logic rd_r;
  logic scl_r;
  logic oe_n_r;
  logic rx_mode;
  logic last_byte;

  assign rx_mode = rd_r && (idx_r == IDX_INSTR);
  assign last_byte = rx_mode || (idx_r == IDX_DATA);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= HS_IDLE;
      ph_r <= 2'h0;
      bit_r <= 3'h0;
      idx_r <= 2'h0;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      instr_r <= 8'h00;
      data_r <= 8'h00;
      rd_r <= 1'b0;
      scl_r <= 1'b1;
      oe_n_r <= 1'b1;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_nack <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      if (state_r == HS_IDLE) begin
        scl_r <= 1'b1;
        oe_n_r <= 1'b1;
        cmd_ready <= 1'b1;
        if (cmd_valid && cmd_ready) begin
          cmd_ready <= 1'b0;
          tx_r <= {DEV_PREFIX, cmd_addr_sel, cmd_read};
          instr_r <= cmd_instr;
          data_r <= cmd_data;
          rd_r <= cmd_read;
          idx_r <= IDX_ADDR;
          rsp_nack <= 1'b0;
          ph_r <= 2'h0;
          state_r <= HS_START;
        end
      end else if (tick) begin
        ph_r <= ph_r + 2'h1;
        case (state_r)
          HS_START: begin
            if (ph_r == 2'h1) begin
              oe_n_r <= 1'b0;
            end else if (ph_r == 2'h2) begin
              scl_r <= 1'b0;
            end else if (ph_r == 2'h3) begin
              bit_r <= 3'h0;
              state_r <= HS_BIT;
            end
          end
          HS_BIT: begin
            if (ph_r == 2'h0) begin
              oe_n_r <= rx_mode ? 1'b1 : tx_r[7];
            end else if (ph_r == 2'h1) begin
              scl_r <= 1'b1;
            end else if (ph_r == 2'h2) begin
              rx_r <= {rx_r[6:0], bus.sda};
            end else begin
              scl_r <= 1'b0;
              tx_r <= {tx_r[6:0], 1'b0};
              bit_r <= bit_r + 3'h1;
              if (bit_r == 3'h7) begin
                state_r <= HS_ACK;
              end
            end
          end
          HS_ACK: begin
            if (ph_r == 2'h0) begin
              // The single read byte is answered with no acknowledge.
              oe_n_r <= 1'b1;
            end else if (ph_r == 2'h1) begin
              scl_r <= 1'b1;
            end else if (ph_r == 2'h2) begin
              if (!rx_mode && bus.sda) begin
                rsp_nack <= 1'b1;
              end
            end else begin
              scl_r <= 1'b0;
              bit_r <= 3'h0;
              if (rsp_nack || last_byte) begin
                state_r <= HS_STOP;
              end else begin
                idx_r <= idx_r + 2'h1;
                tx_r <= (idx_r == IDX_ADDR) ? instr_r : data_r;
                state_r <= HS_BIT;
              end
            end
          end
          HS_STOP: begin
            if (ph_r == 2'h0) begin
              oe_n_r <= 1'b0;
            end else if (ph_r == 2'h1) begin
              scl_r <= 1'b1;
            end else if (ph_r == 2'h2) begin
              oe_n_r <= 1'b1;
            end else begin
              rsp_valid <= 1'b1;
              rsp_data <= rx_r;
              state_r <= HS_IDLE;
            end
          end
          default: begin
            state_r <= HS_IDLE;
          end
        endcase
      end
    end
  end

  assign bus.scl = scl_r;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe_n = oe_n_r;

endmodule

// file: test/dpw_chk.sv
`timescale 1ns/1ps
module dpw_chk (
  input logic sys_clk,
  input logic rstn,
  input logic scl,
  input logic sda,
  input logic s_sda_oe_n,
  input logic [7:0] wiper_position_register,
  input logic [255:0] tap_select,
  input logic shutdown_active
);
  import dpw_pkg::*;
  // ****************************************************************
  // Bus state seen from the wires.
  // ****************************************************************
  logic scl_r;
  logic sda_r;
  logic in_xfer_r;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end else begin
      scl_r <= scl;
      sda_r <= sda;
    end
  end
  // SCL must be high on both samples around the SDA edge, so an SDA change that meets an SCL edge is not taken.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      in_xfer_r <= 1'b0;
    end else if (scl && scl_r && sda_r && !sda) begin
      in_xfer_r <= 1'b1;
    end else if (scl && scl_r && !sda_r && sda) begin
      in_xfer_r <= 1'b0;
    end
  end
  // ****************************************************************
  // Properties.
  // ****************************************************************
  property p_tap_onehot;
    $onehot(tap_select);
  endproperty
  property p_tap_code;
    $stable(wiper_position_register) && $stable(shutdown_active) && !shutdown_active
      |-> tap_select == (TAP_ZERO << wiper_position_register);
  endproperty
  property p_sd_tap;
    shutdown_active && $past(shutdown_active) |-> tap_select == TAP_ZERO;
  endproperty
  property p_drive_scl_low;
    $fell(s_sda_oe_n) |-> !scl;
  endproperty
  property p_release_scl_low;
    $rose(s_sda_oe_n) |-> !scl;
  endproperty
  property p_wiper_preset;
    $rose(rstn) |-> wiper_position_register == WIPER_MIDSCALE;
  endproperty
  property p_change_in_xfer;
    $changed(wiper_position_register) || $changed(shutdown_active) |-> in_xfer_r;
  endproperty
  property p_released_idle;
    !in_xfer_r |-> s_sda_oe_n;
  endproperty
  property p_scl_idle;
    !in_xfer_r |-> scl ##1 scl;
  endproperty
  a_tap_onehot: assert property (p_tap_onehot) else $error("tap not one-hot");
  a_tap_code: assert property (p_tap_code) else $error("tap differs from code");
  a_sd_tap: assert property (p_sd_tap) else $error("shutdown tap not zero");
  a_drive_scl_low: assert property (p_drive_scl_low) else $error("drive at scl high");
  a_release_scl_low: assert property (p_release_scl_low) else $error("release at scl high");
  a_wiper_preset: assert property (p_wiper_preset) else $error("wiper not midscale");
  a_change_in_xfer: assert property (p_change_in_xfer) else $error("change outside frame");
  a_released_idle: assert property (p_released_idle) else $error("sda driven when idle");
  a_scl_idle: assert property (p_scl_idle) else $error("scl low when idle");
  c_shutdown: cover property ($rose(shutdown_active));
  c_ack: cover property ($fell(s_sda_oe_n));
  c_write: cover property ($changed(wiper_position_register));
endmodule

// file: test/dpw_slave_tb.sv
`timescale 1ns/1ps
module dpw_slave_tb;
  import dpw_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic pin = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic cmd_addr_sel = 1'b0;
  logic [7:0] cmd_instr = 8'h00;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ready;
  logic rsp_valid;
  logic rsp_nack;
  logic shutdown_active;
  logic ack;
  logic [7:0] rsp_data;
  logic [7:0] wiper;
  logic [7:0] wiper2;
  logic [255:0] tap;
  int failures = 0;
  int checked = 0;
  dpw_i2c_if bus1 ();
  dpw_i2c_if bus2 ();
  always #2 sys_clk = ~sys_clk;
  // A short quarter keeps the run small; the polling limits on the waits below are sized for it.
  dpw_master #(.QTR_CYC(4)) u_dpw_master (.sys_clk(sys_clk), .rstn(rstn), .bus(bus1.master),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
    .cmd_addr_sel(cmd_addr_sel), .cmd_instr(cmd_instr), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  dpw_slave u_dpw_slave (.sys_clk(sys_clk), .rstn(rstn), .bus(bus1.slave),
    .address_select_pin(pin), .wiper_position_register(wiper), .tap_select(tap),
    .shutdown_active(shutdown_active));
  dpw_slave u_dpw_slave_2 (.sys_clk(sys_clk), .rstn(rstn), .bus(bus2.slave),
    .address_select_pin(1'b1), .wiper_position_register(wiper2), .tap_select(),
    .shutdown_active());
  dpw_chk u_dpw_chk (.sys_clk(sys_clk), .rstn(rstn), .scl(bus1.scl), .sda(bus1.sda),
    .s_sda_oe_n(bus1.s_sda_oe_n), .wiper_position_register(wiper), .tap_select(tap),
    .shutdown_active(shutdown_active));
  // ****************************************************************
  // Tasks.
  // ****************************************************************
  task automatic chk(input string what, input logic [255:0] seen, input logic [255:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic run(input logic rd, sel, input logic [7:0] ins, dat, ew, input logic en, esd);
    int n;
    @(negedge sys_clk);
    cmd_read = rd;
    cmd_addr_sel = sel;
    cmd_instr = ins;
    cmd_data = dat;
    cmd_valid = 1'b1;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    chk("rsp_valid", 256'(rsp_valid), 256'(1'b1));
    chk("rsp_nack", 256'(rsp_nack), 256'(en));
    chk("wiper", 256'(wiper), 256'(ew));
    chk("tap", tap, esd ? TAP_ZERO : TAP_ZERO << ew);
    chk("shutdown", 256'(shutdown_active), 256'(esd));
    if (rd) begin
      chk("rsp_data", 256'(rsp_data), 256'(ew));
    end
  endtask
  task quarter;
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic bb_bit(input logic b, output logic r);
    bus2.m_sda_oe_n = b;
    quarter();
    bus2.scl = 1'b1;
    quarter();
    r = bus2.sda;
    quarter();
    bus2.scl = 1'b0;
    quarter();
  endtask
  task automatic bb_byte(input logic [7:0] v, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bb_bit(v[i], r);
    end
    bb_bit(1'b1, r);
    a = ~r;
  endtask
  task bb_start;
    bus2.m_sda_oe_n = 1'b0;
    quarter();
    bus2.scl = 1'b0;
    quarter();
  endtask
  task bb_stop;
    bus2.m_sda_oe_n = 1'b0;
    quarter();
    bus2.scl = 1'b1;
    quarter();
    bus2.m_sda_oe_n = 1'b1;
    quarter();
  endtask
  // ****************************************************************
  // Sequence.
  // ****************************************************************
  initial begin
    bus2.scl = 1'b1;
    bus2.m_sda_o = 1'b0;
    bus2.m_sda_oe_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    rstn = 1'b1;
    @(negedge sys_clk);
    chk("wiper", 256'(wiper), 256'(WIPER_MIDSCALE));
    chk("tap", tap, TAP_ZERO << 128);
    run(1'b0, 1'b0, 8'h00, 8'h55, 8'h55, 1'b0, 1'b0);
    run(1'b1, 1'b0, 8'h00, 8'h00, 8'h55, 1'b0, 1'b0);
    run(1'b0, 1'b1, 8'h00, 8'h11, 8'h55, 1'b1, 1'b0);
    run(1'b0, 1'b0, 8'h20, 8'h11, 8'h11, 1'b0, 1'b1);
    run(1'b1, 1'b0, 8'h00, 8'h00, 8'h11, 1'b0, 1'b1);
    run(1'b0, 1'b0, 8'h80, 8'h11, 8'h11, 1'b0, 1'b0);
    run(1'b0, 1'b0, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
    run(1'b0, 1'b0, 8'h40, 8'h07, 8'h80, 1'b0, 1'b0);
    @(negedge sys_clk);
    pin = 1'b1;
    run(1'b0, 1'b1, 8'h00, 8'hff, 8'hff, 1'b0, 1'b0);
    run(1'b0, 1'b0, 8'h00, 8'h01, 8'hff, 1'b1, 1'b0);
    bb_start();
    bb_byte({DEV_PREFIX_DEF ^ 6'h01, 2'b10}, ack);
    chk("prefix ack", 256'(ack), 256'(1'b0));
    bb_stop();
    bb_start();
    bb_byte({DEV_PREFIX_DEF, 2'b10}, ack);
    chk("addr ack", 256'(ack), 256'(1'b1));
    bb_byte(8'h00, ack);
    chk("instr ack", 256'(ack), 256'(1'b1));
    bb_byte(8'h33, ack);
    chk("data ack", 256'(ack), 256'(1'b1));
    bb_byte(8'haa, ack);
    chk("extra ack", 256'(ack), 256'(1'b0));
    bb_stop();
    chk("wiper2", 256'(wiper2), 256'(8'h33));
    rstn = 1'b0;
    repeat (2) @(negedge sys_clk);
    rstn = 1'b1;
    @(negedge sys_clk);
    chk("wiper", 256'(wiper), 256'(WIPER_MIDSCALE));
    chk("wiper2", 256'(wiper2), 256'(WIPER_MIDSCALE));
    report_and_stop();
  end
  // Roughly four times the expected length of the sequence above.
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    report_and_stop();
  end
endmodule
